// file: rtl/srq_pkg.sv
/*
  Package for the service request compressor of the A/D converter module:
  register offsets, field positions, reset values and shared types.
  Assumes a 32-bit AHB-Lite register bus, one aligned word per register.
*/
package srq_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_CHAN_FLAG = 8'h04;
  localparam logic [7:0] OFS_MISC_FLAG = 8'h08;
  localparam logic [7:0] OFS_NODE_PTR  = 8'h0C;
  localparam logic [7:0] OFS_MASK      = 8'h10;
  localparam logic [7:0] OFS_CHAN_BASE = 8'h40;

  // Counts
  localparam int NUM_CHAN  = 16;
  localparam int NUM_MISC  = 4;
  localparam int NUM_SRC   = 20;
  localparam int NUM_NODE  = 4;
  localparam int MUX_W     = 3;

  // Module control field positions
  localparam int CTRL_EXPAND_BIT = 0;
  localparam int CTRL_TEST_BIT   = 1;

  // Channel control field positions
  localparam int CC_SEL_LSB  = 0;
  localparam int CC_EN_BIT   = 2;
  localparam int CC_MODE_LSB = 4;
  localparam int CC_MUX_LSB  = 8;

  // Misc source index in second flag register and node pointer register
  localparam int MISC_TIMER = 0;
  localparam int MISC_QUEUE = 1;
  localparam int MISC_SCAN  = 2;
  localparam int MISC_SYNC  = 3;

  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // Limit flag modes
  localparam logic [1:0] LFM_NEVER = 2'h0;
  localparam logic [1:0] LFM_LIMIT = 2'h1;
  localparam logic [1:0] LFM_WRITE = 2'h2;

  // Per-channel control fields
  typedef struct packed {
    logic [MUX_W-1:0] mux_sel;
    logic [1:0]       limit_flag_mode;
    logic             channel_node_enable;
    logic [1:0]       channel_node_select;
  } srq_chan_ctrl_t;

  // Conversion start information from the arbiter
  typedef struct packed {
    logic             valid;
    logic             sequential;
    logic [3:0]       channel;
    logic [MUX_W-1:0] seq_mux;
  } srq_conv_t;

endpackage : srq_pkg

// file: rtl/srq_compressor.sv
/*
  Service request compressor with status flags, node routing, test mode,
  an interrupt mask and the external multiplexer select outputs.
  Assumes an AHB-Lite master on hclk and event pulses from converter logic
  that share hclk.
*/
// Notes on behaviour
// [R1] Expansion enable set: three select outputs drive the external multiplexer.
// [R2] Parallel requests take mux select from the requested channel's control.
// [R3] Sequential requests take mux select from inject or queue request registers.
// [R4] Mux select updates when arbitration ends, before sampling starts.
// [R5] Twenty sources, four nodes; each source maps to any node.
// [R6] Each source has node select and enable; event routed only if enabled.
// [R7] Channel 0-15 flags in first register; timer/queue/scan/sync in second.
// [R8] Per-channel mode: never set, set on limit violation, set on every write.
// [R9] Software polling a channel flag clears that channel's node enable; reads here leave the enable bit as software last wrote it.
// [R10] Each event sets its flag and triggers its node together.
// [R11] Test off: write 1 clears a set flag; write 0 no effect.
// [R12] Clear and set in one cycle: flag stays set, new request issued.
// [R13] Test on: write 1 to clear flag sets it and triggers request.
// [R14] Test on: write 1 to a set flag gives no new request.
// [R15] Test mode bit clears itself after any write to a flag register.
// [R16] All twenty flags are readable from the two flag registers.
// [R17] Each node gives its own separate request to the interrupt controller.
// [R18] Node select is two bits, values 0 to 3 select nodes 0 to 3.
`timescale 1ns/1ps

module srq_compressor
  import srq_pkg::*;
(
  // Clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [7:0]          haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Converter events, one-cycle pulses
  input  wire logic [NUM_CHAN-1:0] result_write,
  input  wire logic [NUM_CHAN-1:0] limit_violation,
  input  wire logic [NUM_MISC-1:0] misc_event,
  input  wire srq_conv_t           conv_start,
  // Service request outputs
  output logic [NUM_NODE-1:0]      request_node,
  output logic                     irq,
  // External multiplexer
  output logic [MUX_W-1:0]         ext_mux_sel
);

  // Registers
  logic                       ext_mux_expand_enable_r;
  logic                       request_test_mode_r;
  logic [NUM_CHAN-1:0]        channel_flag_reg_r;
  logic [NUM_MISC-1:0]        misc_flag_reg_r;
  logic [NUM_MISC*3-1:0]      node_pointer_reg_r;
  logic [NUM_SRC-1:0]         mask_r;
  srq_chan_ctrl_t             chan_ctrl_r [NUM_CHAN];
  logic [MUX_W-1:0]           ext_mux_sel_r;
  logic [NUM_NODE-1:0]        request_node_r;

  // Bus address phase capture
  logic                       wr_pend_r;
  logic [7:0]                 addr_r;
  logic                       acc_en;
  logic                       wr_chan;
  logic                       wr_misc;

  // Source view
  logic [NUM_SRC-1:0]         hw_set;
  logic [NUM_SRC-1:0]         sw_one;
  logic [NUM_SRC-1:0]         flags;
  logic [NUM_SRC-1:0]         flags_nxt;
  logic [NUM_SRC-1:0]         trig;
  logic [NUM_SRC-1:0]         src_en;
  logic [NUM_SRC*2-1:0]       src_sel;
  logic [NUM_NODE-1:0]        request_node_nxt;

  assign acc_en    = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Capture address phase; data follows in the next cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end
    else
    begin
      wr_pend_r <= acc_en && hwrite;
      if (acc_en)
        addr_r <= haddr;
    end
  end

  assign wr_chan = wr_pend_r && (addr_r == OFS_CHAN_FLAG);
  assign wr_misc = wr_pend_r && (addr_r == OFS_MISC_FLAG);

  // Hardware set causes per source
  always_comb
  begin
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      unique case (chan_ctrl_r[i].limit_flag_mode)
        LFM_LIMIT: hw_set[i] = limit_violation[i]; // R8
        LFM_WRITE: hw_set[i] = result_write[i];    // R8
        default:   hw_set[i] = 1'b0;               // R8
      endcase
    end
    hw_set[NUM_SRC-1:NUM_CHAN] = misc_event;       // R7
  end

  // Software ones written to either flag register
  assign sw_one = {wr_misc ? hwdata[NUM_MISC-1:0] : {NUM_MISC{1'b0}},
                   wr_chan ? hwdata[NUM_CHAN-1:0] : {NUM_CHAN{1'b0}}};
  assign flags  = {misc_flag_reg_r, channel_flag_reg_r};

  // Flag update: set beats clear, test writes set only clear flags
  always_comb
  begin
    for (int i = 0; i < NUM_SRC; i++)
    begin
      trig[i] = hw_set[i] || (request_test_mode_r && sw_one[i] && !flags[i]); // R10 R13 R14
      if (trig[i])
        flags_nxt[i] = 1'b1;                         // R12
      else if (sw_one[i] && !request_test_mode_r)
        flags_nxt[i] = 1'b0;                         // R11
      else
        flags_nxt[i] = flags[i];
    end
  end

  // Flag registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      channel_flag_reg_r <= RST_ZERO[NUM_CHAN-1:0];
      misc_flag_reg_r    <= RST_ZERO[NUM_MISC-1:0];
    end
    else
    begin
      channel_flag_reg_r <= flags_nxt[NUM_CHAN-1:0];       // R7
      misc_flag_reg_r    <= flags_nxt[NUM_SRC-1:NUM_CHAN]; // R7
    end
  end

  // Per-source destination and enable
  always_comb
  begin
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      src_en[i]        = chan_ctrl_r[i].channel_node_enable; // R9
      src_sel[i*2 +: 2] = chan_ctrl_r[i].channel_node_select; // R18
    end
    for (int m = 0; m < NUM_MISC; m++)
    begin
      src_en[NUM_CHAN+m]          = node_pointer_reg_r[m*3+2];
      src_sel[(NUM_CHAN+m)*2 +: 2] = node_pointer_reg_r[m*3 +: 2];
    end
  end

  // Compressor: OR enabled triggers into the selected node
  always_comb
  begin
    request_node_nxt = '0;
    for (int i = 0; i < NUM_SRC; i++)
      if (trig[i] && src_en[i])                                // R6
        request_node_nxt[src_sel[i*2 +: 2]] = 1'b1;            // R5 R18
  end

  // Node request pulses, one per node
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      request_node_r <= '0;
    else
      request_node_r <= request_node_nxt; // R17
  end

  assign request_node = request_node_r;
  assign irq          = |(flags & mask_r); // Level, sticky flags gated by mask

  // Control register with self-clearing test bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_mux_expand_enable_r <= RST_ZERO[CTRL_EXPAND_BIT];
      request_test_mode_r     <= RST_ZERO[CTRL_TEST_BIT];
    end
    else if (wr_pend_r && addr_r == OFS_CTRL)
    begin
      ext_mux_expand_enable_r <= hwdata[CTRL_EXPAND_BIT];
      request_test_mode_r     <= hwdata[CTRL_TEST_BIT];
    end
    else if (wr_chan || wr_misc)
      request_test_mode_r <= 1'b0; // R15
  end

  // Node pointer and mask registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      node_pointer_reg_r <= RST_ZERO[NUM_MISC*3-1:0];
      mask_r             <= RST_ZERO[NUM_SRC-1:0];
    end
    else if (wr_pend_r)
    begin
      if (addr_r == OFS_NODE_PTR)
        node_pointer_reg_r <= hwdata[NUM_MISC*3-1:0];
      if (addr_r == OFS_MASK)
        mask_r <= hwdata[NUM_SRC-1:0];
    end
  end

  // Channel control registers, one word each from the channel base
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < NUM_CHAN; i++)
        chan_ctrl_r[i] <= '0;
    end
    else if (wr_pend_r && addr_r[7:6] == OFS_CHAN_BASE[7:6] && addr_r[1:0] == 2'h0)
    begin
      chan_ctrl_r[addr_r[5:2]].channel_node_select <= hwdata[CC_SEL_LSB +: 2];
      chan_ctrl_r[addr_r[5:2]].channel_node_enable <= hwdata[CC_EN_BIT];
      chan_ctrl_r[addr_r[5:2]].limit_flag_mode     <= hwdata[CC_MODE_LSB +: 2];
      chan_ctrl_r[addr_r[5:2]].mux_sel             <= hwdata[CC_MUX_LSB +: MUX_W];
    end
  end

  // External mux select latched at arbitration end, ahead of sampling
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ext_mux_sel_r <= '0;
    else if (conv_start.valid && ext_mux_expand_enable_r)            // R4
    begin
      if (conv_start.sequential)
        ext_mux_sel_r <= conv_start.seq_mux;                         // R3
      else
        ext_mux_sel_r <= chan_ctrl_r[conv_start.channel].mux_sel;    // R2
    end
  end

  // Held at zero while expansion is off
  assign ext_mux_sel = ext_mux_expand_enable_r ? ext_mux_sel_r : '0; // R1

  // Read mux; reads have no side effects
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= RST_ZERO;
    else if (acc_en && !hwrite)
    begin
      hrdata <= RST_ZERO;
      if (haddr[7:6] == OFS_CHAN_BASE[7:6])
        hrdata[CC_MUX_LSB+MUX_W-1:0] <= {chan_ctrl_r[haddr[5:2]].mux_sel, 2'h0,
                                         chan_ctrl_r[haddr[5:2]].limit_flag_mode, 1'b0,
                                         chan_ctrl_r[haddr[5:2]].channel_node_enable,
                                         chan_ctrl_r[haddr[5:2]].channel_node_select};
      else
      begin
        unique case (haddr)
          OFS_CTRL:      hrdata[1:0] <= {request_test_mode_r, ext_mux_expand_enable_r};
          OFS_CHAN_FLAG: hrdata[NUM_CHAN-1:0] <= channel_flag_reg_r;       // R16
          OFS_MISC_FLAG: hrdata[NUM_MISC-1:0] <= misc_flag_reg_r;          // R16
          OFS_NODE_PTR:  hrdata[NUM_MISC*3-1:0] <= node_pointer_reg_r;
          OFS_MASK:      hrdata[NUM_SRC-1:0] <= mask_r;
          default:       hrdata <= RST_ZERO; // Unmapped reads as zero
        endcase
      end
    end
  end

  // Flag assertions; the race is watched on the timer flag
  AST_SET_WINS: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    (hw_set[NUM_CHAN+MISC_TIMER] && sw_one[NUM_CHAN+MISC_TIMER]) |=> (misc_flag_reg_r[MISC_TIMER]
      && (!$past(node_pointer_reg_r[2]) || request_node[$past(node_pointer_reg_r[1:0])])))
    else $error("flag lost or request missed when set met clear");
  AST_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    (wr_chan && !request_test_mode_r && hwdata[3] && !hw_set[3]) |=> !channel_flag_reg_r[3])
    else $error("write one did not clear flag");
  AST_TEST_SET: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    (wr_misc && request_test_mode_r && hwdata[0] && !misc_flag_reg_r[0]) |=> misc_flag_reg_r[0])
    else $error("test write did not set flag");
  AST_TEST_NOREQ: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    (request_test_mode_r && wr_misc && (hwdata[NUM_MISC-1:0] & ~misc_flag_reg_r) == '0 &&
      hw_set == '0) |=> (request_node == '0 && misc_flag_reg_r == $past(misc_flag_reg_r)))
    else $error("request raised or flag lost on test write to set flags");
  AST_TEST_SELFCLR: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    (wr_chan || wr_misc) |=> !request_test_mode_r)
    else $error("test mode not cleared after flag write");
  AST_ROUTE: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    (misc_event[0] && node_pointer_reg_r[2]) |=> request_node[$past(node_pointer_reg_r[1:0])])
    else $error("enabled timer event not routed");
  AST_NO_ROUTE: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    (trig == '0) |=> (request_node == '0))
    else $error("node request without a source");
  AST_FLAG_SET: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    misc_event[1] |=> misc_flag_reg_r[1])
    else $error("queue event did not set flag");
  AST_MODE_NEVER: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    (chan_ctrl_r[1].limit_flag_mode == LFM_NEVER && !sw_one[1] && !channel_flag_reg_r[1])
      |=> !channel_flag_reg_r[1])
    else $error("flag set in never mode");
  AST_MUX_OFF: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    !ext_mux_expand_enable_r |-> (ext_mux_sel == '0))
    else $error("mux select driven while disabled");
  AST_MUX_SEQ: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    (conv_start.valid && conv_start.sequential && ext_mux_expand_enable_r)
      |=> (ext_mux_sel == $past(conv_start.seq_mux)))
    else $error("sequential mux select not applied");
  AST_MUX_PAR: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    (conv_start.valid && !conv_start.sequential && ext_mux_expand_enable_r)
      |=> (ext_mux_sel == chan_ctrl_r[$past(conv_start.channel)].mux_sel))
    else $error("parallel mux select not taken from channel control");
  // Select lines move only at arbitration end or on an enable change
  AST_MUX_HOLD: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    (!conv_start.valid && !(wr_pend_r && addr_r == OFS_CTRL)) |=> $stable(ext_mux_sel))
    else $error("mux select changed outside arbitration end");

  // Further flag, routing and read-back assertions
  AST_HW_SET_ALL: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    (hw_set != '0) |=> ((flags & $past(hw_set)) == $past(hw_set)))
    else $error("source event did not set its flag");
  AST_CLEAR_NONE: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    (wr_chan && !request_test_mode_r && hwdata[5] && !channel_flag_reg_r[5] && !hw_set[5])
      |=> !channel_flag_reg_r[5])
    else $error("write one set a clear flag outside test mode");
  AST_TEST_REQ: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    (wr_misc && request_test_mode_r && hwdata[0] && !misc_flag_reg_r[0] &&
      node_pointer_reg_r[2])
      |=> request_node[$past(node_pointer_reg_r[1:0])])
    else $error("test write set flag without request");
  AST_ROUTE_CHAN: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    (result_write[2] && chan_ctrl_r[2].limit_flag_mode == LFM_WRITE &&
      chan_ctrl_r[2].channel_node_enable)
      |=> request_node[$past(chan_ctrl_r[2].channel_node_select)])
    else $error("enabled channel event not routed");
  AST_NO_EN: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    (trig[0] && trig[NUM_SRC-1:1] == '0 && !chan_ctrl_r[0].channel_node_enable)
      |=> (request_node == '0))
    else $error("disabled channel source reached a node");
  AST_MODE_SPARE: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    (chan_ctrl_r[0].limit_flag_mode == 2'h3 && !sw_one[0] && !channel_flag_reg_r[0])
      |=> !channel_flag_reg_r[0])
    else $error("flag set in spare never mode");
  AST_READ_CHAN: assert property (@(posedge hclk) disable iff (!hresetn) // R16
    (acc_en && !hwrite && haddr == OFS_CHAN_FLAG)
      |=> (hrdata[NUM_CHAN-1:0] == $past(channel_flag_reg_r)))
    else $error("channel flags not returned on read");
  AST_READ_MISC: assert property (@(posedge hclk) disable iff (!hresetn) // R16
    (acc_en && !hwrite && haddr == OFS_MISC_FLAG)
      |=> (hrdata[NUM_MISC-1:0] == $past(misc_flag_reg_r)))
    else $error("misc flags not returned on read");

  COV_ROUTE: cover property (@(posedge hclk) disable iff (!hresetn) |request_node);
  COV_TEST: cover property (@(posedge hclk) disable iff (!hresetn)
    request_test_mode_r && wr_chan);
  COV_RACE: cover property (@(posedge hclk) disable iff (!hresetn) |(hw_set & sw_one));
  COV_IRQ: cover property (@(posedge hclk) disable iff (!hresetn) irq);

endmodule : srq_compressor

// file: tb/srq_icu_model.sv
/*
  Interrupt controller stand-in that counts pulses on each request node.
  Assumes one-cycle request pulses on hclk.
*/
`timescale 1ns/1ps
module srq_icu_model
  import srq_pkg::*;
(
  // Clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // Node requests in, one count byte per node out
  input  wire logic [NUM_NODE-1:0] request_node,
  output logic [31:0]              taken
);
  // Each node counted apart, as each has its own vector
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      taken <= 32'h0000_0000;
    else
      for (int i = 0; i < NUM_NODE; i++)
        if (request_node[i])
          taken[8*i +: 8] <= taken[8*i +: 8] + 8'h01;
  end
endmodule : srq_icu_model

// file: tb/test_srq_compressor.sv
/*
  Self-checking bench for the service request compressor.
  Assumes a single AHB-Lite master, zero-wait slave and one hclk domain.
*/
`timescale 1ns/1ps
module test_srq_compressor;
  import srq_pkg::*;
  // Design and bench signals
  logic                hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, rph;
  logic [7:0]          haddr;
  logic [1:0]          htrans;
  logic [2:0]          hsize, ext_mux_sel, mx;
  logic [31:0]         hwdata, hrdata, taken, exp_taken;
  logic [NUM_CHAN-1:0] result_write, limit_violation;
  logic [NUM_MISC-1:0] misc_event;
  logic [NUM_NODE-1:0] request_node;
  srq_conv_t           conv_start;
  logic [31:0]         rd_q[$];
  logic [3:0]          rq[$];
  logic [7:0]          ofs [8] = '{OFS_CTRL, OFS_CHAN_FLAG, OFS_MISC_FLAG, OFS_NODE_PTR,
                                   OFS_MASK, OFS_CHAN_BASE, 8'h7C, 8'h20};
  int                  n_errors = 0;
  int                  cmp_count = 0;
  int                  seed = 35;
  int                  sel;

  assign hready = hreadyout;

  srq_compressor dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .result_write(result_write),
    .limit_violation(limit_violation), .misc_event(misc_event), .conv_start(conv_start),
    .request_node(request_node), .irq(irq), .ext_mux_sel(ext_mux_sel));

  srq_icu_model icu_u (.hclk(hclk), .hresetn(hresetn), .request_node(request_node),
    .taken(taken));

  // Clock
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  // Note an expected request pulse and its count at the node
  task automatic want(input logic [3:0] v);
    rq.push_back(v);
    for (int i = 0; i < NUM_NODE; i++)
      exp_taken[8*i +: 8] += 8'(v[i]);
  endtask : want

  // One single transfer; ev pulses misc events during the data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [3:0] ev = 4'h0);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    if (!w)
      rd_q.push_back(e);
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'($random(seed));
    misc_event <= ev;
    do @(posedge hclk); while (hready !== 1'b1);
    misc_event <= 4'h0;
  endtask : bus

  task automatic pulse(input logic [15:0] rw, input logic [15:0] lv, input logic [3:0] me);
    @(posedge hclk);
    result_write <= rw;
    limit_violation <= lv;
    misc_event <= me;
    @(posedge hclk);
    result_write <= '0;
    limit_violation <= '0;
    misc_event <= '0;
  endtask : pulse

  // Arbitration end for channel 3, then look at the select lines
  task automatic conv(input logic sq, input logic [2:0] m, input logic [2:0] e);
    @(posedge hclk);
    conv_start <= '{1'b1, sq, 4'h3, m};
    @(posedge hclk);
    conv_start <= '0;
    @(negedge hclk);
    check(32'(ext_mux_sel), 32'(e));
  endtask : conv

  // Result watcher: oldest note against each read and each request pulse
  always @(posedge hclk)
  begin
    rph <= hsel & hready & htrans[1] & !hwrite;
    if (rph)
    begin
      check(hrdata, rd_q.pop_front());
      check(32'(hresp), 32'h0);
    end
    if (request_node !== '0)
      check(32'(request_node), rq.size() ? 32'(rq.pop_front()) : 32'h0);
  end

  // Watchdog, well past the expected few hundred cycles
  initial
  begin
    #(8 * 20000);
    n_errors++;
    close_out();
  end

  initial
  begin
    {hresetn, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
    {result_write, limit_violation, misc_event, conv_start, exp_taken} = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (ofs[i])
      bus(0, ofs[i], 0, 0);
    // Every channel on a random node, result-write mode
    for (int n = 0; n < NUM_CHAN; n++)
    begin
      sel = $random(seed) & 3;
      bus(1, OFS_CHAN_BASE + 8'(4 * n), (32'(LFM_WRITE) << CC_MODE_LSB) | 32'h4 | sel, 0);
      want(4'(1 << sel));
      pulse(16'(1 << n), 0, 0);
    end
    bus(0, OFS_CHAN_FLAG, 0, 32'h0000_FFFF);
    bus(1, OFS_CHAN_FLAG, 32'h0000_00FF, 0);
    bus(0, OFS_CHAN_FLAG, 0, 32'h0000_FF00);
    bus(1, OFS_CHAN_FLAG, 32'h0000_FFFF, 0);
    bus(0, OFS_CHAN_FLAG, 0, 32'h0);
    // Flag modes on channel 0
    bus(1, OFS_CHAN_BASE, 32'h0000_0005, 0);
    pulse(16'h1, 16'h1, 0);
    bus(0, OFS_CHAN_FLAG, 0, 32'h0);
    bus(1, OFS_CHAN_BASE, 32'h0000_0035, 0);
    pulse(16'h1, 16'h1, 0);
    bus(0, OFS_CHAN_FLAG, 0, 32'h0);
    bus(1, OFS_CHAN_BASE, 32'h0000_0016, 0);
    pulse(16'h1, 0, 0);
    want(4'h4);
    pulse(0, 16'h1, 0);
    bus(1, OFS_CHAN_FLAG, 32'h1, 0);
    bus(1, OFS_CHAN_BASE, 32'h0000_0012, 0);
    pulse(0, 16'h1, 0);
    bus(0, OFS_CHAN_FLAG, 0, 32'h1);
    // Test-mode set of a polled channel flag raises no node request
    bus(1, OFS_CHAN_FLAG, 32'h1, 0);
    bus(1, OFS_CTRL, 32'h2, 0);
    bus(1, OFS_CHAN_FLAG, 32'h1, 0);
    bus(0, OFS_CHAN_FLAG, 0, 32'h1);
    // Misc sources to nodes 3,2,1,0, timer unmasked
    bus(1, OFS_NODE_PTR, 32'h0000_0977, 0);
    bus(1, OFS_MASK, 32'h0001_0000, 0);
    want(4'hF);
    pulse(0, 0, 4'hF);
    @(negedge hclk);
    check(32'(irq), 32'h1);
    bus(0, OFS_MISC_FLAG, 0, 32'hF);
    bus(0, OFS_NODE_PTR, 0, 32'h0000_0977);
    want(4'h8);
    bus(1, OFS_MISC_FLAG, 32'h1, 0, 4'h1);
    bus(0, OFS_MISC_FLAG, 0, 32'hF);
    bus(1, OFS_MISC_FLAG, 32'hF, 0);
    @(negedge hclk);
    check(32'(irq), 32'h0);
    // Software set in test mode, then a repeat on a set flag
    bus(1, OFS_CTRL, 32'h2, 0);
    want(4'h8);
    bus(1, OFS_MISC_FLAG, 32'h1, 0);
    bus(0, OFS_MISC_FLAG, 0, 32'h1);
    bus(0, OFS_CTRL, 0, 32'h0);
    bus(1, OFS_CTRL, 32'h2, 0);
    bus(1, OFS_MISC_FLAG, 32'h1, 0);
    bus(0, OFS_MISC_FLAG, 0, 32'h1);
    bus(0, OFS_CTRL, 0, 32'h0);
    // External multiplexer selection
    mx = 3'($random(seed));
    bus(1, OFS_CHAN_BASE + 8'h0C, 32'(mx) << CC_MUX_LSB, 0);
    conv(0, ~mx, 3'h0);
    bus(1, OFS_CTRL, 32'h1, 0);
    conv(0, ~mx, mx);
    conv(1, mx ^ 3'h7, mx ^ 3'h7);
    repeat (4) @(posedge hclk);
    check(32'(rq.size()), 32'h0);
    check(taken, exp_taken);
    close_out();
  end
endmodule : test_srq_compressor
